// ==== src/bus_decode_pkg.sv ====
// Package with address map, field positions and carriers for the bus decoder
package bus_decode_pkg;

  localparam int          ADDR_W           = 16;
  localparam int          DATA_W           = 8;
  localparam logic [15:0] INT_LOW_LAST     = 16'h3fff;
  localparam logic [15:0] INT_HIGH_FIRST   = 16'he000;
  localparam logic [15:0] EXT_FIRST        = 16'h4000;
  localparam logic [15:0] EXT_LAST         = 16'hdfff;
  localparam logic [15:0] SWITCH_REG_ADDR  = 16'h3000;
  localparam logic [15:0] PAGE0_LAST       = 16'h00c7;
  localparam logic [15:0] PERIPH_FIRST     = 16'h0080;
  localparam logic [15:0] PIA_LAST         = 16'h008f;
  localparam logic [15:0] CTRL_FIRST       = 16'h00c0;
  localparam int          PAGE0_HI_MSB     = 15;
  localparam int          PAGE0_HI_LSB     = 11;
  localparam int          PAGE0_MID_MSB    = 10;
  localparam int          PAGE0_MID_LSB    = 8;
  localparam int          PERIPH_BIT       = 7;
  localparam int          CTRL_BIT         = 6;
  localparam logic [7:0]  LATCH_RESET      = 8'h00;

  // Decoded selects, all held in flip-flops at the top
  typedef struct packed {
    logic int_data_select_n;
    logic int_read_enable;
    logic write_latch_oe_n;
    logic ext_xcvr_enable;
    logic ext_dir_to_cpu;
    logic periph_region_select_n;
    logic controller_select;
    logic pia_select;
    logic own_ram_select;
    logic switch_read;
  } decode_sel_t;

endpackage

// ==== src/write_data_latch.sv ====
// Transparent-when-high write data latch modelled on the system clock
`timescale 1ns/1ns
module write_data_latch
  import bus_decode_pkg::*;
#(
  parameter int WIDTH = DATA_W
) (
  // Clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_reset,
  // Data path
  input  wire logic             i_phase2,
  input  wire logic [WIDTH-1:0] i_data,
  output logic      [WIDTH-1:0] o_data
);

  logic [WIDTH-1:0] hold_reg;
  logic [WIDTH-1:0] hold_next;

  // Follow while phase 2 high, hold last value otherwise
  always_comb begin
    hold_next = i_phase2 ? i_data : hold_reg;
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      hold_reg <= '0;
    end else begin
      hold_reg <= hold_next;
    end
  end

  assign o_data = hold_reg;

  AST_LATCH_HOLDS: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    !$past(i_phase2) |-> hold_reg == $past(hold_reg))
    else $error("write latch changed while phase 2 low");

endmodule

// ==== src/cpu_bus_decode_steering.sv ====
// Address decoder and data bus steering for the processor board
`timescale 1ns/1ns
module cpu_bus_decode_steering
  import bus_decode_pkg::*;
(
  // Clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_reset,
  // Processor side
  input  wire logic              i_buffered_phase2_clock,
  input  wire logic              i_buffered_valid_address,
  input  wire logic              i_buffered_read_write,
  input  wire logic [ADDR_W-1:0] i_internal_address_lines,
  input  wire logic [DATA_W-1:0] i_processor_data_lines,
  output logic      [DATA_W-1:0] o_processor_data_lines,
  output logic                   o_processor_data_oe,
  // Internal bus
  input  wire logic [DATA_W-1:0] i_internal_data_lines,
  output logic      [DATA_W-1:0] o_internal_data_lines,
  output logic                   o_internal_data_oe,
  output logic                   o_internal_bus_data_select_n,
  output logic                   o_internal_read_enable,
  // External bus
  input  wire logic [DATA_W-1:0] i_external_data_lines,
  output logic      [DATA_W-1:0] o_external_data_lines,
  output logic                   o_external_data_oe,
  output logic                   o_external_xcvr_enable,
  output logic                   o_external_dir_to_cpu,
  // Page 0 and switch register
  input  wire logic [DATA_W-1:0] i_address_switches,
  output logic                   o_peripheral_region_select_n,
  output logic                   o_controller_select,
  output logic                   o_adapter_select,
  output logic                   o_adapter_phase2_clock,
  output logic                   o_own_ram_select,
  output logic                   o_switch_read,
  output logic      [DATA_W-1:0] o_circuit_select_latch
);

  decode_sel_t      sel_reg;
  decode_sel_t      sel_next;
  logic [DATA_W-1:0] cpu_data_reg;
  logic [DATA_W-1:0] cpu_data_next;
  logic              cpu_oe_reg;
  logic              cpu_oe_next;
  logic [DATA_W-1:0] ext_data_reg;
  logic [DATA_W-1:0] ext_data_next;
  logic [DATA_W-1:0] csl_reg;
  logic [DATA_W-1:0] csl_next;
  logic              phase2_reg;
  logic [DATA_W-1:0] latch_data;
  logic              int_oe_reg;
  logic              int_oe_next;
  logic              ext_oe_reg;
  logic              ext_oe_next;

  logic [ADDR_W-1:0] a;
  logic              rd;
  logic              wr;
  logic              p2;
  logic              vma;
  logic              in_int_range;
  logic              in_ext_range;
  logic              page0_ok;
  logic              own_ram;
  logic              periph;
  logic              ctrl_hit;
  logic              pia_hit;
  logic              switch_hit;

  assign a  = i_internal_address_lines;
  assign p2 = i_buffered_phase2_clock;
  assign vma = i_buffered_valid_address;
  assign rd = vma && i_buffered_read_write;
  assign wr = vma && !i_buffered_read_write;

  write_data_latch #(
    .WIDTH (DATA_W)
  ) u_write_latch (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_phase2  (p2),
    .i_data    (i_processor_data_lines),
    .o_data    (latch_data)
  );

  // Address decode
  always_comb begin
    in_int_range = (a <= INT_LOW_LAST) || (a >= INT_HIGH_FIRST);
    in_ext_range = (a >= EXT_FIRST) && (a <= EXT_LAST);
    page0_ok     = (a[PAGE0_HI_MSB:PAGE0_HI_LSB] == 5'h00)
                && (a[PAGE0_MID_MSB:PAGE0_MID_LSB] == 3'h0);
    own_ram      = page0_ok && !a[PERIPH_BIT];
    periph       = page0_ok && a[PERIPH_BIT];
    ctrl_hit     = periph && a[CTRL_BIT] && (a <= PAGE0_LAST)
                && (a >= CTRL_FIRST);
    pia_hit      = periph && !a[CTRL_BIT] && (a >= PERIPH_FIRST)
                && (a <= PIA_LAST);
    switch_hit   = (a == SWITCH_REG_ADDR);
  end

  // Select and steering next values
  always_comb begin
    sel_next = '0;
    sel_next.int_data_select_n = 1'b1;
    sel_next.write_latch_oe_n  = 1'b1;
    sel_next.periph_region_select_n = 1'b1;
    sel_next.ext_dir_to_cpu = i_buffered_read_write;
    if (vma) begin
      sel_next.own_ram_select = own_ram;
      sel_next.switch_read    = switch_hit && rd;
      sel_next.periph_region_select_n = !periph;
      sel_next.controller_select = ctrl_hit && p2 && vma;
      sel_next.pia_select = pia_hit;
      // Internal bus off for own RAM and switch reads
      if (in_int_range && !own_ram && !(switch_hit && rd)) begin
        sel_next.int_data_select_n = 1'b0;
        sel_next.int_read_enable   = rd && p2;
        sel_next.write_latch_oe_n  = !wr;
      end else if (in_ext_range && !p2) begin
        sel_next.ext_xcvr_enable = 1'b1;
      end
    end
  end

  // Data steering next values
  always_comb begin
    cpu_data_next = cpu_data_reg;
    cpu_oe_next   = 1'b0;
    ext_data_next = latch_data;
    csl_next      = csl_reg;
    // Enables registered so the pins come straight from flops
    int_oe_next   = !sel_next.write_latch_oe_n;
    ext_oe_next   = sel_next.ext_xcvr_enable && !sel_next.ext_dir_to_cpu;
    if (sel_next.switch_read) begin
      cpu_data_next = i_address_switches;
      cpu_oe_next   = 1'b1;
    end else if (sel_next.int_read_enable) begin
      cpu_data_next = i_internal_data_lines;
      cpu_oe_next   = 1'b1;
    end else if (sel_next.ext_xcvr_enable && i_buffered_read_write) begin
      cpu_data_next = i_external_data_lines;
      cpu_oe_next   = 1'b1;
    end
    if (vma && switch_hit && wr && !p2) begin
      csl_next = latch_data;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      sel_reg      <= '{int_data_select_n: 1'b1, write_latch_oe_n: 1'b1,
                        periph_region_select_n: 1'b1, ext_dir_to_cpu: 1'b1,
                        default: 1'b0};
      cpu_data_reg <= '0;
      cpu_oe_reg   <= 1'b0;
      ext_data_reg <= '0;
      csl_reg      <= LATCH_RESET;
      phase2_reg   <= 1'b0;
      int_oe_reg   <= 1'b0;
      ext_oe_reg   <= 1'b0;
    end else begin
      sel_reg      <= sel_next;
      cpu_data_reg <= cpu_data_next;
      cpu_oe_reg   <= cpu_oe_next;
      ext_data_reg <= ext_data_next;
      csl_reg      <= csl_next;
      phase2_reg   <= p2;
      int_oe_reg   <= int_oe_next;
      ext_oe_reg   <= ext_oe_next;
    end
  end

  assign o_processor_data_lines       = cpu_data_reg;
  assign o_processor_data_oe          = cpu_oe_reg;
  assign o_internal_data_lines        = latch_data;
  assign o_internal_data_oe           = int_oe_reg;
  assign o_internal_bus_data_select_n = sel_reg.int_data_select_n;
  assign o_internal_read_enable       = sel_reg.int_read_enable;
  assign o_external_data_lines        = ext_data_reg;
  assign o_external_data_oe           = ext_oe_reg;
  assign o_external_xcvr_enable       = sel_reg.ext_xcvr_enable;
  assign o_external_dir_to_cpu        = sel_reg.ext_dir_to_cpu;
  assign o_peripheral_region_select_n = sel_reg.periph_region_select_n;
  assign o_controller_select          = sel_reg.controller_select;
  assign o_adapter_select             = sel_reg.pia_select;
  assign o_adapter_phase2_clock       = phase2_reg;
  assign o_own_ram_select             = sel_reg.own_ram_select;
  assign o_switch_read                = sel_reg.switch_read;
  assign o_circuit_select_latch       = csl_reg;

  // Checks
  AST_NO_BOTH_BUSES: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    !(!sel_reg.int_data_select_n && sel_reg.ext_xcvr_enable))
    else $error("internal and external paths both enabled");

  AST_READ_BUF_COND: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    sel_reg.int_read_enable |-> $past(rd && p2) && !sel_reg.int_data_select_n)
    else $error("read buffer enabled outside read phase 2");

  AST_WRITE_NO_READ: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    $past(wr) |-> !sel_reg.int_read_enable)
    else $error("read buffer on during write");

  AST_INT_RANGE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    $past(vma && a >= 16'he000) |-> !sel_reg.int_data_select_n)
    else $error("internal select missing for high rom");

  AST_EXT_LOW_PHASE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    sel_reg.ext_xcvr_enable |-> !$past(p2) && $past(in_ext_range))
    else $error("external transceiver on outside low phase");

  AST_EXT_DIR: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    sel_reg.ext_dir_to_cpu == $past(i_buffered_read_write))
    else $error("transceiver direction wrong");

  AST_OWN_RAM_OFF: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    sel_reg.own_ram_select |-> sel_reg.int_data_select_n && !sel_reg.ext_xcvr_enable)
    else $error("bus enabled during own ram access");

  AST_CTRL_GATED: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    sel_reg.controller_select |-> $past(p2 && vma) && !sel_reg.periph_region_select_n)
    else $error("controller select without phase 2 and valid");

  AST_SWITCH_ISOLATE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    sel_reg.switch_read |-> sel_reg.int_data_select_n && !sel_reg.ext_xcvr_enable
    && cpu_data_reg == $past(i_address_switches))
    else $error("switch read not isolated");

  AST_UNMAPPED_IDLE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    $past(!vma) |-> sel_reg.int_data_select_n && !sel_reg.ext_xcvr_enable
    && !sel_reg.pia_select && !sel_reg.controller_select)
    else $error("select active without valid address");

  // Page 0, select latch and driver checks
  AST_PAGE0_GATE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (sel_reg.own_ram_select || !sel_reg.periph_region_select_n)
    |-> $past(vma) && ($past(a[PAGE0_HI_MSB:PAGE0_MID_LSB]) == 8'h00))
    else $error("page 0 select with upper address bits set");

  AST_BIT7_SPLIT: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    $past(vma && (a[PAGE0_HI_MSB:PAGE0_MID_LSB] == 8'h00))
    |-> (sel_reg.own_ram_select == !$past(a[PERIPH_BIT]))
    && (sel_reg.periph_region_select_n == !$past(a[PERIPH_BIT])))
    else $error("bit 7 split wrong in page 0");

  AST_ADAPTER_SIDE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    sel_reg.pia_select |-> !$past(a[CTRL_BIT]) && !sel_reg.periph_region_select_n
    && ($past(a) >= PERIPH_FIRST) && ($past(a) <= PIA_LAST))
    else $error("adapter select outside its range");

  AST_CTRL_SIDE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    sel_reg.controller_select |-> $past(a[CTRL_BIT]) && ($past(a) >= CTRL_FIRST)
    && ($past(a) <= PAGE0_LAST))
    else $error("controller select outside its range");

  AST_GAP_NO_DEVICE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    $past(vma && (a[PAGE0_HI_MSB:PAGE0_MID_LSB] == 8'h00)
    && (((a > PIA_LAST) && (a < CTRL_FIRST)) || (a > PAGE0_LAST)))
    |-> !sel_reg.pia_select && !sel_reg.controller_select)
    else $error("device selected in unmapped page 0 gap");

  AST_ADAPTER_CLOCK: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    !$past(i_reset) |-> phase2_reg == $past(p2))
    else $error("adapter clock does not follow phase 2");

  AST_CSL_LOAD: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    $past(vma && !i_buffered_read_write && !p2 && (a == SWITCH_REG_ADDR))
    |-> csl_reg == $past(latch_data))
    else $error("select latch missed write to 3000");

  AST_CSL_STEADY: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    !$past(vma && !i_buffered_read_write && (a == SWITCH_REG_ADDR)) |-> $stable(csl_reg))
    else $error("select latch changed without write to 3000");

  AST_LATCH_DRIVE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    int_oe_reg |-> $past(wr) && !sel_reg.int_data_select_n)
    else $error("write latch drives bus outside internal write");

  AST_CPU_DRIVE_READ: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    cpu_oe_reg |-> $past(rd))
    else $error("processor data driven outside a read");

  COV_INT_READ: cover property (@(posedge i_sys_clk) sel_reg.int_read_enable);
  COV_EXT_WRITE: cover property (@(posedge i_sys_clk)
    sel_reg.ext_xcvr_enable && !sel_reg.ext_dir_to_cpu);
  COV_SWITCH: cover property (@(posedge i_sys_clk) sel_reg.switch_read);
  COV_CTRL: cover property (@(posedge i_sys_clk) sel_reg.controller_select);
  COV_OWN_RAM: cover property (@(posedge i_sys_clk) sel_reg.own_ram_select);

endmodule

// ==== bench/far_side_model.sv ====
// Memory and peripheral chips seen across the decoder's buses
`timescale 1ns/1ns
module far_side_model
  import bus_decode_pkg::*;
(
  // Clock
  input  wire logic              i_sys_clk,
  // Bus controls
  input  wire logic              i_valid,
  input  wire logic              i_read,
  input  wire logic [ADDR_W-1:0] i_addr,
  // Data returned
  output logic      [DATA_W-1:0] o_int_data,
  output logic      [DATA_W-1:0] o_ext_data,
  output logic      [DATA_W-1:0] o_switches
);
  logic [DATA_W-1:0] idle_reg = 8'h00;
  logic              drive;
  assign drive = i_valid & i_read;
  // Released lines show a pattern that changes every cycle
  always @(posedge i_sys_clk) idle_reg <= idle_reg + 8'h5b;
  assign o_int_data = drive ? (i_addr[7:0] ^ 8'h3c) : idle_reg;
  assign o_ext_data = drive ? (i_addr[7:0] ^ 8'hc3) : ~idle_reg;
  // Switch setting, arbitrary
  assign o_switches = 8'h17;
endmodule

// ==== bench/tb_cpu_bus_decode_steering.sv ====
// Directed bench for the processor bus decoder and steering block
`timescale 1ns/1ns
module tb_cpu_bus_decode_steering;
  import bus_decode_pkg::*;
  logic              clk, rst, p2, vma, rw;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, pdo, ido, edo, latch, sw, idi, edi;
  logic              poe, ioe, isel_n, ird, eoe, xen, dir;
  logic              reg_n, csel, asel, ap2, ram, swr;
  int                fail_count, total_checks, cycles;

  cpu_bus_decode_steering u_cpu_bus_decode_steering (
    .i_sys_clk(clk), .i_reset(rst), .i_buffered_phase2_clock(p2),
    .i_buffered_valid_address(vma), .i_buffered_read_write(rw),
    .i_internal_address_lines(addr), .i_processor_data_lines(wdata),
    .o_processor_data_lines(pdo), .o_processor_data_oe(poe),
    .i_internal_data_lines(idi), .o_internal_data_lines(ido),
    .o_internal_data_oe(ioe), .o_internal_bus_data_select_n(isel_n),
    .o_internal_read_enable(ird), .i_external_data_lines(edi),
    .o_external_data_lines(edo), .o_external_data_oe(eoe),
    .o_external_xcvr_enable(xen), .o_external_dir_to_cpu(dir),
    .i_address_switches(sw), .o_peripheral_region_select_n(reg_n),
    .o_controller_select(csel), .o_adapter_select(asel),
    .o_adapter_phase2_clock(ap2), .o_own_ram_select(ram),
    .o_switch_read(swr), .o_circuit_select_latch(latch));

  far_side_model u_far_side_model (
    .i_sys_clk(clk), .i_valid(vma), .i_read(rw), .i_addr(addr),
    .o_int_data(idi), .o_ext_data(edi), .o_switches(sw));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic final_report;
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 500) begin
      fail_count++;
      $display("mismatch at %0t: run did not finish", $time);
      final_report;
    end
  end

  // One bus cycle: inputs set at falling edge, result seen after next rise
  task automatic acc(input logic v, input logic r, input logic c,
                     input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge clk);
    vma = v;
    rw = r;
    p2 = c;
    addr = a;
    wdata = d;
    @(posedge clk);
    #1;
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp)
      $display("mismatch at %0t: %s got %b want %b", $time, what, got, exp);
    if (got !== exp)
      fail_count++;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp)
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    if (got !== exp)
      fail_count++;
  endtask

  initial begin
    logic [ADDR_W-1:0] ia[4] = '{16'h2000, 16'h3fff, 16'he000, 16'hffff};
    rst = 1'b1;
    p2 = 1'b0;
    vma = 1'b0;
    rw = 1'b1;
    addr = 16'h0100;
    wdata = 8'h00;
    fail_count = 0;
    total_checks = 0;
    cycles = 0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    foreach (ia[i]) begin
      acc(1'b1, 1'b1, 1'b1, ia[i], 8'h00);
      chk1(isel_n, 1'b0, "int select");
      chk1(ird, 1'b1, "read buffer");
      chk1(xen, 1'b0, "ext xcvr");
      chk8(pdo, ia[i][7:0] ^ 8'h3c, "int read data");
      chk1(poe, 1'b1, "cpu drive read");
    end
    acc(1'b1, 1'b1, 1'b0, 16'h3fff, 8'h00);
    chk1(ird, 1'b0, "read buffer low phase");
    acc(1'b0, 1'b1, 1'b1, 16'h2000, 8'h00);
    chk1(ird, 1'b0, "read buffer no valid");
    $display("test internal reads done");
    acc(1'b1, 1'b0, 1'b1, 16'h2000, 8'ha6);
    chk1(ird, 1'b0, "read buffer on write");
    chk1(ioe, 1'b1, "latch drive");
    chk8(ido, 8'ha6, "latch follow");
    chk1(poe, 1'b0, "cpu drive off write");
    acc(1'b1, 1'b0, 1'b0, 16'h2000, 8'h59);
    acc(1'b1, 1'b0, 1'b0, 16'h2000, 8'h59);
    chk8(ido, 8'ha6, "latch hold");
    $display("test internal writes done");
    acc(1'b1, 1'b1, 1'b0, 16'h4000, 8'h00);
    chk1(xen, 1'b1, "ext xcvr read");
    chk1(dir, 1'b1, "dir read");
    chk1(isel_n, 1'b1, "int select ext");
    chk8(pdo, 8'hc3, "ext read data");
    acc(1'b1, 1'b0, 1'b1, 16'hdfff, 8'h33);
    chk1(xen, 1'b0, "ext xcvr high phase");
    chk1(ioe, 1'b0, "latch off ext");
    chk8(ido, 8'h33, "latch loads while off");
    acc(1'b1, 1'b0, 1'b0, 16'hdfff, 8'h33);
    chk1(dir, 1'b0, "dir write");
    chk1(eoe, 1'b1, "ext drive");
    chk8(edo, 8'h33, "ext write data");
    $display("test external bus done");
    acc(1'b1, 1'b1, 1'b1, 16'h3000, 8'h00);
    chk1(swr, 1'b1, "switch read");
    chk8(pdo, 8'h17, "switch data");
    chk1(isel_n, 1'b1, "int off switch");
    chk1(xen, 1'b0, "ext off switch");
    acc(1'b1, 1'b0, 1'b1, 16'h3000, 8'h5a);
    acc(1'b1, 1'b0, 1'b0, 16'h3000, 8'h5a);
    acc(1'b0, 1'b1, 1'b1, 16'h0100, 8'h00);
    chk8(latch, 8'h5a, "select latch");
    $display("test address 3000 done");
    acc(1'b1, 1'b1, 1'b1, 16'h0040, 8'h00);
    chk1(ram, 1'b1, "own ram");
    chk1(ird, 1'b0, "int off own ram");
    chk1(isel_n, 1'b1, "int select own ram");
    chk1(reg_n, 1'b1, "region off");
    acc(1'b1, 1'b1, 1'b1, 16'h0085, 8'h00);
    chk1(asel, 1'b1, "adapter");
    chk1(reg_n, 1'b0, "region on");
    chk1(ram, 1'b0, "own ram off");
    chk1(ap2, 1'b1, "adapter clock high");
    acc(1'b1, 1'b1, 1'b0, 16'h0085, 8'h00);
    chk1(ap2, 1'b0, "adapter clock low");
    acc(1'b1, 1'b1, 1'b1, 16'h00c3, 8'h00);
    chk1(csel, 1'b1, "controller");
    chk1(asel, 1'b0, "adapter off");
    acc(1'b1, 1'b1, 1'b0, 16'h00c3, 8'h00);
    chk1(csel, 1'b0, "controller low phase");
    acc(1'b0, 1'b1, 1'b1, 16'h00c3, 8'h00);
    chk1(csel, 1'b0, "controller no valid");
    acc(1'b1, 1'b1, 1'b1, 16'h0840, 8'h00);
    chk1(ram, 1'b0, "page0 high bits");
    acc(1'b1, 1'b1, 1'b1, 16'h0140, 8'h00);
    chk1(ram, 1'b0, "page0 mid bits");
    acc(1'b1, 1'b1, 1'b1, 16'h00d0, 8'h00);
    chk1(csel, 1'b0, "gap controller");
    chk1(asel, 1'b0, "gap adapter");
    $display("test page 0 done");
    final_report;
  end
endmodule
